// File: core/rra_map.vh
// Purpose: register offsets, field positions, reset values, mode codes and response codes
// Assumes: word-indexed register offsets, byte address is four times the index
// Notes:   definitions only
`ifndef RRA_MAP_VH
`define RRA_MAP_VH

// register indices; byte address = index * 4
`define RRA_IDX_START_LO     8'h0c
`define RRA_IDX_START_HI     8'h0d
`define RRA_IDX_ROT_CTRL     8'h1b
`define RRA_IDX_STRIDE       8'h1c
`define RRA_IDX_GEOM         8'h20
`define RRA_IDX_STATUS       8'h21
`define RRA_ADDR_START_LO    12'h030
`define RRA_ADDR_START_HI    12'h034
`define RRA_ADDR_ROT_CTRL    12'h06c
`define RRA_ADDR_STRIDE      12'h070
`define RRA_ADDR_GEOM        12'h080
`define RRA_ADDR_STATUS      12'h084

// rotation control fields
`define RRA_ROT_EN_BIT       7
`define RRA_ROT_SEL_BIT      6
`define RRA_ROT_DIV_HI       1
`define RRA_ROT_DIV_LO       0
`define RRA_ROT_CTRL_MASK    8'hc3

// reset values
`define RRA_RST_START        16'h0000
`define RRA_RST_ROT_CTRL     8'h00
`define RRA_RST_STRIDE       8'h00
`define RRA_RST_LINES        8'h10
`define RRA_RST_BYTES        8'h08

// mode codes
`define RRA_MODE_LAND        2'b00
`define RRA_MODE_PRIM        2'b01
`define RRA_MODE_SEC         2'b10

// axi responses
`define RRA_RESP_OKAY        2'b00
`define RRA_RESP_SLVERR      2'b10

`endif

// File: core/rra_skid.v
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: one clock, asynchronous active-low reset, clock enable
// Notes:   in_ready depends only on fill level, so no combinational path
`timescale 1ns/1ns
module rra_skid #(
    parameter WIDTH = 16
) (
    // clock and reset
    input  wire             core_clk_in,
    input  wire             arst_n_in,
    input  wire             clk_en_in,
    // filling side
    input  wire             in_valid_in,
    output wire             in_ready_out,
    input  wire [WIDTH-1:0] in_data_in,
    // draining side
    output wire             out_valid_out,
    input  wire             out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem_q [0:1];
    reg             wp_q;
    reg             rp_q;
    reg [1:0]       cnt_q;
    wire            push;
    wire            pop;

    assign in_ready_out  = (cnt_q != 2'd2);
    assign out_valid_out = (cnt_q != 2'd0);
    assign out_data_out  = mem_q[rp_q];
    assign push = in_valid_in && in_ready_out;
    assign pop  = out_valid_out && out_ready_in;

    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wp_q     <= 1'b0;
            rp_q     <= 1'b0;
            cnt_q    <= 2'd0;
            mem_q[0] <= {WIDTH{1'b0}};
            mem_q[1] <= {WIDTH{1'b0}};
        end else if (clk_en_in) begin
            if (push) begin
                mem_q[wp_q] <= in_data_in;
                wp_q        <= ~wp_q;
            end
            if (pop) begin
                rp_q <= ~rp_q;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 2'd1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 2'd1;
            end
        end
    end
endmodule

// File: core/rra_core.v
// Purpose: rotated display-refresh address generator with AXI4-Lite registers
// Assumes: memory clock is the core clock; pixel strobe derived by divider
// Notes:   addresses leave through a two-entry buffer toward the memory port
// Function
// - enable=1, variant=0 selects the primary rotation mode.
// - enable=1, variant=1 selects the secondary rotation mode.
// - exactly two rotated variants, both done in refresh hardware.
// - rotated fetch order is B, D, A, C of host image.
// - each rotated frame starts at refresh start address (corner B).
// - primary mode steps lines by stride bytes (virtual width).
// - secondary mode steps lines by stride (actual width), no virtual image.
// - start address plus one pans one byte horizontally.
// - primary vertical pan is two lines per twice the stride.
// - secondary mode: one stride added pans exactly one line.
// - no split screen when rotated; single region from start address.
// - enable=0 gives landscape refresh, variant bit ignored.
// - divide select gives /1,/2,/4,/8 when rotated, landscape always /1; secondary memory clock at least twice pixel.
`timescale 1ns/1ns
`include "rra_map.vh"
module rra_core #(
    parameter AW = 16
) (
    // clock, reset, enable
    input  wire          core_clk_in,
    input  wire          arst_n_in,
    input  wire          clk_en_in,
    // axi4-lite write address
    input  wire          s_axi_awvalid,
    output reg           s_axi_awready,
    input  wire [11:0]   s_axi_awaddr,
    // axi4-lite write data
    input  wire          s_axi_wvalid,
    output reg           s_axi_wready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    // axi4-lite write response
    output reg           s_axi_bvalid,
    input  wire          s_axi_bready,
    output reg  [1:0]    s_axi_bresp,
    // axi4-lite read address
    input  wire          s_axi_arvalid,
    output reg           s_axi_arready,
    input  wire [11:0]   s_axi_araddr,
    // axi4-lite read data
    output reg           s_axi_rvalid,
    input  wire          s_axi_rready,
    output reg  [31:0]   s_axi_rdata,
    output reg  [1:0]    s_axi_rresp,
    // refresh fetch address stream to display buffer
    output reg           fetch_valid_out,
    input  wire          fetch_ready_in,
    output reg  [AW-1:0] fetch_addr_out,
    // status pins
    output reg           pixel_stb_out,
    output reg           frame_start_out,
    output reg  [1:0]    mode_out
);
    // registers
    reg [15:0]   start_q;
    reg [7:0]    rot_ctrl_q;
    reg [7:0]    stride_q;
    reg [7:0]    lines_q;
    reg [7:0]    bytes_q;
    // frame-latched shadows
    reg [7:0]    f_stride_q;
    reg [1:0]    f_mode_q;
    // walk state
    reg [AW-1:0] col_base_q;
    reg [AW-1:0] addr_q;
    reg [7:0]    line_q;
    reg [7:0]    col_q;
    reg          busy_q;
    reg [1:0]    st_q;
    reg [2:0]    div_q;
    reg [15:0]   frames_q;
    // write channel holding
    reg          aw_have_q;
    reg          w_have_q;
    reg [11:0]   aw_addr_q;
    reg [31:0]   w_data_q;
    reg [3:0]    w_strb_q;

    localparam ST_IDLE  = 2'd0;
    localparam ST_FRAME = 2'd1;
    localparam ST_WALK  = 2'd2;

    wire          buf_in_ready;
    wire          buf_out_valid;
    wire [AW-1:0] buf_out_data;
    wire          gen_valid;
    wire          gen_push;
    wire [1:0]    cur_mode;
    wire [3:0]    div_lim;
    wire          pix_tick;
    wire          wr_go;

    function [1:0] mode_of;
        input [7:0] ctrl;
        begin
            if (!ctrl[`RRA_ROT_EN_BIT]) begin
                mode_of = `RRA_MODE_LAND;
            end else if (!ctrl[`RRA_ROT_SEL_BIT]) begin
                mode_of = `RRA_MODE_PRIM;
            end else begin
                mode_of = `RRA_MODE_SEC;
            end
        end
    endfunction

    function [31:0] reg_rd;
        input [11:0] a;
        begin
            case (a)
                `RRA_ADDR_START_LO: reg_rd = {24'h000000, start_q[7:0]};
                `RRA_ADDR_START_HI: reg_rd = {24'h000000, start_q[15:8]};
                `RRA_ADDR_ROT_CTRL: reg_rd = {24'h000000, rot_ctrl_q};
                `RRA_ADDR_STRIDE:   reg_rd = {24'h000000, stride_q};
                `RRA_ADDR_GEOM:     reg_rd = {16'h0000, bytes_q, lines_q};
                `RRA_ADDR_STATUS:   reg_rd = {frames_q, 8'h00, 4'h0, busy_q,
                                              1'b0, f_mode_q};
                default:            reg_rd = 32'h00000000;
            endcase
        end
    endfunction

    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `RRA_ADDR_START_LO) || (a == `RRA_ADDR_START_HI) ||
                     (a == `RRA_ADDR_ROT_CTRL) || (a == `RRA_ADDR_STRIDE) ||
                     (a == `RRA_ADDR_GEOM) || (a == `RRA_ADDR_STATUS);
        end
    endfunction

    assign cur_mode = mode_of(rot_ctrl_q);
    assign wr_go    = aw_have_q && w_have_q && !s_axi_bvalid;

    // pixel divide 1/2/4/8 when rotated, landscape fixed at 1; secondary code 00 still divides by 2
    assign div_lim = (f_mode_q == `RRA_MODE_SEC && rot_ctrl_q[1:0] == 2'b00) ? 4'd1 :
                     (f_mode_q == `RRA_MODE_LAND) ? 4'd0 :
                     ((4'd1 << rot_ctrl_q[1:0]) - 4'd1);
    assign pix_tick = ({1'b0, div_q} == div_lim);
    assign gen_valid = (st_q == ST_WALK) && pix_tick;
    assign gen_push  = gen_valid && buf_in_ready;

    // register bus
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RRA_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RRA_RESP_OKAY;
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 12'h000;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
            start_q       <= `RRA_RST_START;
            rot_ctrl_q    <= `RRA_RST_ROT_CTRL;
            stride_q      <= `RRA_RST_STRIDE;
            lines_q       <= `RRA_RST_LINES;
            bytes_q       <= `RRA_RST_BYTES;
        end else if (clk_en_in) begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(aw_addr_q) ? `RRA_RESP_OKAY : `RRA_RESP_SLVERR;
                if (w_strb_q[0]) begin
                    case (aw_addr_q)
                        `RRA_ADDR_START_LO: start_q[7:0]  <= w_data_q[7:0];
                        `RRA_ADDR_START_HI: start_q[15:8] <= w_data_q[7:0];
                        // reserved bits held at zero
                        `RRA_ADDR_ROT_CTRL: rot_ctrl_q <= w_data_q[7:0] & `RRA_ROT_CTRL_MASK;
                        `RRA_ADDR_STRIDE:   stride_q   <= w_data_q[7:0];
                        `RRA_ADDR_GEOM:     lines_q    <= w_data_q[7:0];
                        default:            lines_q    <= lines_q;
                    endcase
                end
                if (w_strb_q[1] && aw_addr_q == `RRA_ADDR_GEOM) begin
                    bytes_q <= w_data_q[15:8];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= reg_rd(s_axi_araddr);
                s_axi_rresp  <= mapped(s_axi_araddr) ? `RRA_RESP_OKAY : `RRA_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // refresh walk
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q       <= ST_IDLE;
            f_stride_q <= `RRA_RST_STRIDE;
            f_mode_q   <= `RRA_MODE_LAND;
            col_base_q <= {AW{1'b0}};
            addr_q     <= {AW{1'b0}};
            line_q     <= 8'h00;
            col_q      <= 8'h00;
            busy_q     <= 1'b0;
            div_q      <= 3'd0;
            frames_q   <= 16'h0000;
        end else if (clk_en_in) begin
            if (st_q == ST_WALK && !pix_tick) begin
                div_q <= div_q + 3'd1;
            end else if (gen_push || st_q != ST_WALK) begin
                div_q <= 3'd0;
            end
            case (st_q)
                ST_IDLE: begin
                    busy_q <= 1'b0;
                    st_q   <= ST_FRAME;
                end
                ST_FRAME: begin
                    // shadow at frame start; single region
                    f_stride_q <= stride_q;
                    f_mode_q   <= cur_mode;
                    col_base_q <= start_q[AW-1:0];
                    addr_q     <= start_q[AW-1:0];
                    line_q     <= 8'h00;
                    col_q      <= 8'h00;
                    busy_q     <= 1'b1;
                    frames_q   <= frames_q + 16'h0001;
                    st_q       <= ST_WALK;
                end
                ST_WALK: begin
                    if (gen_push) begin
                        if (col_q == lines_q - 8'h01) begin
                            col_q <= 8'h00;
                            if (line_q == bytes_q - 8'h01) begin
                                st_q <= ST_IDLE;
                            end else begin
                                line_q <= line_q + 8'h01;
                                if (f_mode_q == `RRA_MODE_LAND) begin
                                    addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
                                end else begin
                                    // next column walks leftward, B toward A
                                    col_base_q <= col_base_q - {{(AW-1){1'b0}}, 1'b1};
                                    addr_q     <= col_base_q - {{(AW-1){1'b0}}, 1'b1};
                                end
                            end
                        end else begin
                            col_q <= col_q + 8'h01;
                            if (f_mode_q == `RRA_MODE_LAND) begin
                                addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
                            end else begin
                                // step by stride; B down to D
                                // pan follows from start and stride
                                addr_q <= addr_q + {{(AW-8){1'b0}}, f_stride_q};
                            end
                        end
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    rra_skid #(
        .WIDTH (AW)
    ) u_buf (
        .core_clk_in   (core_clk_in),
        .arst_n_in     (arst_n_in),
        .clk_en_in     (clk_en_in),
        .in_valid_in   (gen_valid),
        .in_ready_out  (buf_in_ready),
        .in_data_in    (addr_q),
        .out_valid_out (buf_out_valid),
        .out_ready_in  (fetch_ready_in || !fetch_valid_out),
        .out_data_out  (buf_out_data)
    );

    // registered outputs
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fetch_valid_out <= 1'b0;
            fetch_addr_out  <= {AW{1'b0}};
            pixel_stb_out   <= 1'b0;
            frame_start_out <= 1'b0;
            mode_out        <= `RRA_MODE_LAND;
        end else if (clk_en_in) begin
            if (fetch_ready_in || !fetch_valid_out) begin
                fetch_valid_out <= buf_out_valid;
                fetch_addr_out  <= buf_out_data;
            end
            pixel_stb_out   <= gen_push;
            frame_start_out <= (st_q == ST_FRAME);
            mode_out        <= f_mode_q;
        end
    end
endmodule

// File: tb/rra_core_props.sv
// Purpose: port-level properties of the rotated refresh core
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   attached to every core instance by the bind below
`timescale 1ns/1ns
module rra_core_props #(
    parameter AW = 16
) (
    input wire          core_clk_in,
    input wire          arst_n_in,
    input wire          s_axi_awvalid,
    input wire          s_axi_awready,
    input wire          s_axi_bvalid,
    input wire          s_axi_bready,
    input wire [1:0]    s_axi_bresp,
    input wire          s_axi_arvalid,
    input wire          s_axi_arready,
    input wire [11:0]   s_axi_araddr,
    input wire          s_axi_rvalid,
    input wire          s_axi_rready,
    input wire [31:0]   s_axi_rdata,
    input wire [1:0]    s_axi_rresp,
    input wire          fetch_valid_out,
    input wire          fetch_ready_in,
    input wire [AW-1:0] fetch_addr_out,
    input wire          pixel_stb_out,
    input wire          frame_start_out,
    input wire [1:0]    mode_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    sequence s_aw_taken;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence s_ar_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h0f0;
    endsequence
    sequence s_fetch_stall;
        fetch_valid_out && !fetch_ready_in;
    endsequence
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    chk_fetch_hold: assert property (s_fetch_stall |=>
        fetch_valid_out && $stable(fetch_addr_out)) else $error("fetch address lost");
    chk_wr_answer: assert property (s_aw_taken |-> ##[1:4] s_axi_bvalid)
        else $error("write response late");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_rd_refused: assert property (s_ar_unmapped |=>
        s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read answered");
    chk_mode_legal: assert property (mode_out != 2'b11)
        else $error("third rotation mode seen");
    // a mode change away from a frame load would tear the picture
    chk_mode_frame: assert property ($changed(mode_out) |->
        (frame_start_out || $past(frame_start_out)) or (##1 frame_start_out))
        else $error("mode changed inside a frame");
    chk_sec_pace: assert property (mode_out == 2'b10 && pixel_stb_out |=>
        !pixel_stb_out) else $error("secondary pixel pace too fast");
endmodule
bind rra_core rra_core_props #(.AW(AW)) u_props (
    .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .fetch_valid_out(fetch_valid_out),
    .fetch_ready_in(fetch_ready_in), .fetch_addr_out(fetch_addr_out),
    .pixel_stb_out(pixel_stb_out), .frame_start_out(frame_start_out), .mode_out(mode_out));

// File: tb/rra_fetch_sink.sv
// Purpose: display buffer read port taking refresh addresses
// Assumes: one address taken per cycle while ready is high
// Notes:   stalls come from the bench so the buffer is exercised
`timescale 1ns/1ns
module rra_fetch_sink (
    // clock and reset
    input  wire clk_in,
    input  wire rst_n_in,
    // stream
    input  wire valid_in,
    input  wire stall_in,
    output reg  ready_out
);
    // ready is dropped even while valid is up: the source must hold its address
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            ready_out <= 1'b0;
        else
            ready_out <= !stall_in || !valid_in;
    end
endmodule

// File: tb/test_rotated_refresh_addressing.sv
// Purpose: self-checking bench for the rotated refresh core
// Assumes: geometry left at reset, 16 addresses by 8 lines a frame
// Notes:   expected addresses queue up only once a new setting is surely live
`timescale 1ns/1ns
module test_rotated_refresh_addressing;
    reg          clk = 1'b0;
    reg          rst_n = 1'b0;
    reg          awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, stall = 0;
    reg  [11:0]  awa = 0, ara = 0;
    reg  [31:0]  wd = 0;
    reg  [16:0]  seed = 17'd82386;
    wire         awr, wr, bv, arr, rv, fv, fr, stb, fs;
    wire [1:0]   br, rr, mode;
    wire [31:0]  rd;
    wire [15:0]  fa;
    integer      errors = 0, compares = 0, cycles = 0, pos = 0;
    reg          live = 0;
    logic [1:0]  wr_q[$];
    logic [33:0] rd_q[$];
    logic [15:0] ad_q[$];
    logic [1:0]  md_q[$];
    always #5 clk = ~clk;
    rra_core #(.AW(16)) uut (
        .core_clk_in(clk), .arst_n_in(rst_n), .clk_en_in(1'b1),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rd), .s_axi_rresp(rr),
        .fetch_valid_out(fv), .fetch_ready_in(fr), .fetch_addr_out(fa),
        .pixel_stb_out(stb), .frame_start_out(fs), .mode_out(mode));
    rra_fetch_sink sink (.clk_in(clk), .rst_n_in(rst_n), .valid_in(fv),
        .stall_in(stall), .ready_out(fr));
    function [16:0] lfsr(input [16:0] s);
        lfsr = {s[15:0], s[16] ^ s[13]};
    endfunction
    task close_out;
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task check(input [95:0] what, input [33:0] exp, input [33:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("wrong value %0s expected %h seen %h", what, exp, got);
        end
    endtask
    // ready for the answer is sometimes raised only once the answer stands,
    // so that the slave has to hold its response
    task axw(input [11:0] a, input [7:0] d, input [1:0] r);
        reg done;
        done = 1'b0;
        wr_q.push_back(r);
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= seed[1];
        @(posedge clk);
        while (!done) begin
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
            if (bv && bre) begin
                bre <= 1'b0;
                done = 1'b1;
            end else if (bv) begin
                bre <= 1'b1;
            end
            @(posedge clk);
        end
    endtask
    task axr(input [11:0] a, input [33:0] e);
        reg done;
        done = 1'b0;
        rd_q.push_back(e);
        ara <= a;
        arv <= 1'b1;
        rre <= seed[2];
        @(posedge clk);
        while (!done) begin
            if (arr) arv <= 1'b0;
            if (rv && rre) begin
                rre <= 1'b0;
                done = 1'b1;
            end else if (rv) begin
                rre <= 1'b1;
            end
            @(posedge clk);
        end
    endtask
    task run(input [7:0] ctrl, input [15:0] st, input [7:0] sd);
        integer c, i;
        axw(12'h030, st[7:0], 2'b00);
        axw(12'h034, st[15:8], 2'b00);
        axw(12'h070, sd, 2'b00);
        axw(12'h06c, ctrl, 2'b00);
        // the first frame start may still belong to the old setting
        @(posedge clk iff fs);
        @(posedge clk iff fs);
        @(negedge clk);
        md_q.push_back(ctrl[7] ? (ctrl[6] ? 2'b10 : 2'b01) : 2'b00);
        for (c = 0; c < 8; c = c + 1)
            for (i = 0; i < 16; i = i + 1)
                ad_q.push_back(16'(ctrl[7] ? st - c + i * sd : st + c * 16 + i));
        while (ad_q.size() > 0) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            errors = errors + 1;
            close_out;
        end
    end
    always @(posedge clk) begin
        if (bv && bre) check("bresp", {32'h0, wr_q.pop_front()}, {32'h0, br});
        if (rv && rre) check("rdata", rd_q.pop_front(), {rr, rd});
        if (fv && fr) begin
            if (pos == 0) live = ad_q.size() > 0;
            if (live && pos == 0)
                check("mode", {32'h0, md_q.pop_front()}, {32'h0, mode});
            if (live) check("fetch", {18'h0, ad_q.pop_front()}, {18'h0, fa});
            pos = (pos + 1) % 128;
        end
        stall <= seed[0] & seed[3];
        seed <= lfsr(seed);
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        axr(12'h030, 34'h0);
        axr(12'h034, 34'h0);
        axr(12'h06c, 34'h0);
        axr(12'h070, 34'h0);
        axr(12'h080, 34'h0810);
        axr(12'h0f0, {2'b10, 32'h0});
        axw(12'h0f0, 8'hff, 2'b10);
        axw(12'h06c, 8'h3c, 2'b00);
        axr(12'h06c, 34'h0);
        axw(12'h070, 8'h5a, 2'b00);
        axr(12'h070, 34'h5a);
        // memory clock is the core clock, pixel pace divided from it
        run(8'h40, 16'h1234, 8'h00);
        run(8'h80, 16'h0077, 8'h80);
        run(8'h81, 16'h0177, 8'h80);
        run(8'hc0, 16'h009f, 8'ha0);
        run(8'hc3, 16'h0140, 8'ha0);
        run(8'h82, seed[15:0], seed[16:9]);
        close_out;
    end
endmodule
